// ===== hw/dadc_pwm_gen.sv
`timescale 1ns/1ps
module dadc_pwm_gen #(
    parameter int CW = 14,
    parameter int AW = 12
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic signed [AW-1:0] accel_x_i,
    input  wire logic signed [AW-1:0] accel_y_i,
    input  wire logic                 rate_sel_i,
    input  wire logic                 ext_clk_sel_i,
    input  wire logic                 ext_clk_i,
    output logic                      pwm_x_o,
    output logic                      pwm_y_o,
    output logic                      rate_fast_o
);
    localparam int DW = $clog2(dadc_pkg::INT_DIV_CYC);

    logic [DW-1:0]        div_ff;
    logic [DW-1:0]        nxt_div;
    logic                 strap_done_ff;
    logic                 rate_ff;
    logic                 ext_sel_ff;
    logic                 nxt_strap_done;
    logic                 nxt_rate;
    logic                 nxt_ext_sel;
    logic                 ext_q_ff;
    logic                 int_tick;
    logic                 ext_tick;
    logic                 tick;
    logic [CW-1:0]        period;
    logic [CW-1:0]        cnt_per_g;
    logic signed [AW-1:0] accel [2];
    logic                 pwm   [2];

    ////////////////////////////////////////////////////////////////////////
    // straps caught once after reset release
    always_comb begin
        nxt_strap_done = 1'b1;
        nxt_rate       = strap_done_ff ? rate_ff : rate_sel_i;
        nxt_ext_sel    = strap_done_ff ? ext_sel_ff : ext_clk_sel_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // internal sensor clock divider and external clock edge
    always_comb begin
        int_tick = (div_ff == DW'(dadc_pkg::INT_DIV_CYC - 1));
        nxt_div  = int_tick ? '0 : div_ff + DW'(1);
        ext_tick = ext_clk_i && !ext_q_ff;
        tick     = strap_done_ff && (ext_sel_ff ? ext_tick : int_tick);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff        <= '0;
            strap_done_ff <= 1'b0;
            rate_ff       <= dadc_pkg::RATE_SLOW;
            ext_sel_ff    <= 1'b0;
            ext_q_ff      <= 1'b0;
        end else begin
            div_ff        <= nxt_div;
            strap_done_ff <= nxt_strap_done;
            rate_ff       <= nxt_rate;
            ext_sel_ff    <= nxt_ext_sel;
            ext_q_ff      <= ext_clk_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period and scale for the chosen option
    always_comb begin
        if (rate_ff == dadc_pkg::RATE_FAST) begin
            period    = CW'(dadc_pkg::PERIOD_FAST_TCK);
            cnt_per_g = CW'(dadc_pkg::CNT_PER_G_FAST);
        end else begin
            period    = CW'(dadc_pkg::PERIOD_SLOW_TCK);
            cnt_per_g = CW'(dadc_pkg::CNT_PER_G_SLOW);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one independent generator per axis
    assign accel[0] = accel_x_i;
    assign accel[1] = accel_y_i;
    for (genvar g = 0; g < 2; g++) begin : g_axis
        dadc_axis_pwm #(
            .CW (CW),
            .AW (AW)
        ) u_axis (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .tick_i      (tick),
            .period_i    (period),
            .cnt_per_g_i (cnt_per_g),
            .accel_i     (accel[g]),
            .pwm_o       (pwm[g])
        );
    end

    assign pwm_x_o     = pwm[0];
    assign pwm_y_o     = pwm[1];
    assign rate_fast_o = rate_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_int_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_done_ff && !ext_sel_ff && tick |=> !tick [*8])
        else $error("internal tick too frequent");
    a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_done_ff |=> $stable(rate_ff) && $stable(ext_sel_ff))
        else $error("period option changed after start");
    a_ext_tick_src: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_done_ff && ext_sel_ff && tick |-> ext_clk_i && !ext_q_ff)
        else $error("external tick without clock edge");
    a_period_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        period == (rate_ff ? CW'(dadc_pkg::PERIOD_FAST_TCK) : CW'(dadc_pkg::PERIOD_SLOW_TCK)))
        else $error("period does not follow option");
endmodule : dadc_pwm_gen

// ===== hw/dadc_pkg.sv
// How it works
// - two independent pwm outputs, x and y, duty tracks each axis acceleration
// - zero acceleration gives half duty, the zero-g reference point
// - scale factor is one fifth of the period duty change per g
// - period fixed at start to 8000 or 2000 sensor clock ticks, 10 ms (100 Hz) or 2.5 ms (400 Hz) on the internal clock
// - internal sensor clock near 800 kHz, optional external clock 400 kHz to 1.6 MHz
package dadc_pkg;
    // system clock
    localparam int SYS_CLK_HZ      = 100_000_000;
    // internal sensor clock and its divider from the system clock
    localparam int INT_CLK_HZ      = 800_000;
    localparam int INT_DIV_CYC     = SYS_CLK_HZ / INT_CLK_HZ;
    // period options in microseconds
    localparam int PERIOD_SLOW_US  = 10_000;
    localparam int PERIOD_FAST_US  = 2_500;
    // period options in sensor clock ticks
    localparam int PERIOD_SLOW_TCK = INT_CLK_HZ / 1000 * PERIOD_SLOW_US / 1000;
    localparam int PERIOD_FAST_TCK = INT_CLK_HZ / 1000 * PERIOD_FAST_US / 1000;
    // duty at zero g and duty change per g, in percent
    localparam int ZERO_G_DUTY_PCT = 50;
    localparam int SCALE_PCT_PER_G = 20;
    localparam int CNT_PER_G_SLOW  = PERIOD_SLOW_TCK * SCALE_PCT_PER_G / 100;
    localparam int CNT_PER_G_FAST  = PERIOD_FAST_TCK * SCALE_PCT_PER_G / 100;
    // fraction bits of the acceleration input (lsb = 1/1024 g)
    localparam int ACCEL_FRAC      = 10;
    // strap encoding of the period option
    localparam logic RATE_SLOW     = 1'b0;
    localparam logic RATE_FAST     = 1'b1;
    // reset values
    localparam logic PWM_RST       = 1'b0;
endpackage : dadc_pkg

// ===== hw/dadc_axis_pwm.sv
`timescale 1ns/1ps
module dadc_axis_pwm #(
    parameter int CW = 14,
    parameter int AW = 12
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 tick_i,
    input  wire logic [CW-1:0]        period_i,
    input  wire logic [CW-1:0]        cnt_per_g_i,
    input  wire logic signed [AW-1:0] accel_i,
    output logic                      pwm_o
);
    localparam int PW = AW + CW + 1;

    logic [CW-1:0]        cnt_ff;
    logic [CW-1:0]        nxt_cnt;
    logic [CW-1:0]        on_time_ff;
    logic [CW-1:0]        nxt_on_time;
    logic                 pwm_ff;
    logic                 nxt_pwm;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] on_calc;
    logic [CW-1:0]        on_clamp;
    logic                 wrap;

    ////////////////////////////////////////////////////////////////////////
    // on time from acceleration: half period plus counts per g times a
    always_comb begin
        prod    = PW'(accel_i) * $signed({{(PW-CW){1'b0}}, cnt_per_g_i});
        on_calc = $signed({{(PW-CW){1'b0}}, period_i >> 1})
                  + (prod >>> dadc_pkg::ACCEL_FRAC);
        if (on_calc < 0) begin
            on_clamp = '0;
        end else if (on_calc > $signed({{(PW-CW){1'b0}}, period_i})) begin
            on_clamp = period_i;
        end else begin
            on_clamp = on_calc[CW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period counter, on time reloaded at each period boundary
    assign wrap = (cnt_ff >= period_i - CW'(1));
    always_comb begin
        nxt_cnt     = cnt_ff;
        nxt_on_time = on_time_ff;
        if (tick_i) begin
            if (wrap) begin
                nxt_cnt     = '0;
                nxt_on_time = on_clamp;
            end else begin
                nxt_cnt = cnt_ff + CW'(1);
            end
        end
        nxt_pwm = (cnt_ff < on_time_ff);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff     <= '0;
            on_time_ff <= '0;
            pwm_ff     <= dadc_pkg::PWM_RST;
        end else begin
            cnt_ff     <= nxt_cnt;
            on_time_ff <= nxt_on_time;
            pwm_ff     <= nxt_pwm;
        end
    end

    assign pwm_o = pwm_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_period_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_i && wrap |=> cnt_ff == '0)
        else $error("period counter did not wrap");
    a_on_load: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_i && wrap |=> on_time_ff == $past(on_clamp))
        else $error("on time not loaded at period end");
    a_zero_g_half: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_i && wrap && accel_i == '0 |=> on_time_ff == (period_i >> 1))
        else $error("zero g not at half duty");
    a_pwm_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pwm_o == ($past(cnt_ff) < $past(on_time_ff)))
        else $error("pwm level disagrees with counter");
endmodule : dadc_axis_pwm

// ===== verification/dadc_host_meter.sv
`timescale 1ns/1ps
module dadc_host_meter #(
    // zero-g offset constants, fit from bias at three temperatures; zero here
    parameter int OFS_A = 0,
    parameter int OFS_B = 0,
    parameter int OFS_C = 0,
    parameter int TEMP  = 0
) (
    input  wire logic        clk_i,
    input  wire logic        pwm_i,
    output logic [31:0]      on_cnt_o,
    output logic [31:0]      per_cnt_o,
    output logic             done_o,
    output int               accel_o
);
    logic        last_ff = 1'b0;
    logic [31:0] cnt_ff  = 32'h0;
    // acceleration from duty (lsb 1/1024 g, 20 % per g), plus offset term
    always_comb begin
        accel_o = 0;
        if (per_cnt_o > 0) begin
            accel_o = (2 * int'(on_cnt_o) - int'(per_cnt_o)) * 2560 / int'(per_cnt_o);
        end
        accel_o = accel_o + OFS_A + OFS_B * TEMP + OFS_C * TEMP * TEMP;
    end
    // one meter per sensor line, edge timing in clk cycles
    always @(posedge clk_i) begin
        last_ff <= pwm_i;
        done_o  <= 1'b0;
        cnt_ff  <= cnt_ff + 32'h1;
        if (pwm_i && !last_ff) begin
            per_cnt_o <= cnt_ff;
            cnt_ff    <= 32'h1;
            done_o    <= 1'b1;
        end
        if (!pwm_i && last_ff) on_cnt_o <= cnt_ff;
    end
endmodule : dadc_host_meter

// ===== verification/test_dual_axis_duty_cycle_decoder.sv
`timescale 1ns/1ps
module test_dual_axis_duty_cycle_decoder;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic signed [11:0] accel_x_i = 12'h000;
    logic signed [11:0] accel_y_i = 12'h000;
    logic               rate_sel_i = 1'b1;
    logic               ext_clk_sel_i = 1'b1;
    logic               ext_clk_i = 1'b0;
    logic               pwm_x_o, pwm_y_o, rate_fast_o, done_x, done_y;
    logic [31:0]        on_x, per_x, on_y, per_y;
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 seed = 75378;
    int                 n_cyc = 0;
    int                 per_tck = 2000;
    int                 ax, ay;
    int                 dec_x, dec_y;

    dadc_pwm_gen dut (.clk_i(clk_i), .rst_i(rst_i), .accel_x_i(accel_x_i),
        .accel_y_i(accel_y_i), .rate_sel_i(rate_sel_i), .ext_clk_sel_i(ext_clk_sel_i),
        .ext_clk_i(ext_clk_i), .pwm_x_o(pwm_x_o), .pwm_y_o(pwm_y_o),
        .rate_fast_o(rate_fast_o));
    dadc_host_meter mx (.clk_i(clk_i), .pwm_i(pwm_x_o), .on_cnt_o(on_x),
        .per_cnt_o(per_x), .done_o(done_x), .accel_o(dec_x));
    dadc_host_meter my (.clk_i(clk_i), .pwm_i(pwm_y_o), .on_cnt_o(on_y),
        .per_cnt_o(per_y), .done_o(done_y), .accel_o(dec_y));

    ////////////////////////////////////////////////////////////////////////////
    // clocks: system 100 MHz, sensor clock one tick per two cycles
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) ext_clk_i <= #1 ~ext_clk_i;
    // hang guard
    always @(posedge clk_i) begin
        n_cyc++;
        if (n_cyc == 100000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // expected on time in ticks, clamped to the period
    function automatic int exp_on(input int a, input int p);
        int on;
        on = p / 2 + ((a * p / 5) >>> 10);
        if (on < 0) on = 0;
        if (on > p) on = p;
        return on;
    endfunction : exp_on

    task automatic check(input string what, input logic [31:0] got, input int exp);
        n_checks++;
        if (got !== 32'(exp)) begin
            n_errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : check

    // decoded acceleration may differ from the applied one by rounding only
    task automatic check_near(input string what, input int got, input int exp);
        n_checks++;
        if (got - exp > 3 || exp - got > 3) begin
            n_errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : check_near

    // two full periods, then compare both axes
    task automatic meas();
        repeat (2) @(posedge done_x);
        #1;
        check("x on", on_x, 2 * exp_on(int'(accel_x_i), per_tck));
        check("y on", on_y, 2 * exp_on(int'(accel_y_i), per_tck));
        check("x period", per_x, 2 * per_tck);
        check("y period", per_y, 2 * per_tck);
        check("x counts per g", per_x / 5, 2 * per_tck / 5);
        check_near("x decoded", dec_x, int'(accel_x_i));
        check_near("y decoded", dec_y, int'(accel_y_i));
    endtask : meas

    task automatic apply(input int a_x, input int a_y);
        @(posedge done_x);
        #1;
        accel_x_i = 12'(a_x);
        accel_y_i = 12'(a_y);
        meas();
    endtask : apply

    task automatic restart(input logic rate, input int p);
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        rate_sel_i = rate;
        per_tck = p;
        repeat (20) @(posedge clk_i);
        #1;
        check("pwm in reset", {30'h0, pwm_x_o, pwm_y_o}, 0);
        rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        rate_sel_i = ~rate; // later strap change must be ignored
        check("rate", {31'h0, rate_fast_o}, int'(rate));
    endtask : restart

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    // fast rate with corners and random, then slow rate
    initial begin
        restart(1'b1, 2000);
        apply(0, 0);
        apply(1024, -1024);
        apply(1, -1);
        ax = $random(seed) % 1025;
        ay = $random(seed) % 1025;
        apply(ax, ay);
        restart(1'b0, 8000);
        meas();
        stop_test();
    end
endmodule : test_dual_axis_duty_cycle_decoder
